/* verilog/spcrc_core.sv */
// SPI master/slave transfer engine with status flags, checksums and an AHB-Lite slave.
`timescale 1ns/1ns
`default_nettype none
`include "spcrc_regs.svh"
// Operation
// - Writing the data register clears the transmit-empty flag.
// - Reading the data register clears the receive-full flag.
// - Busy is driven by hardware only; status writes cannot change it.
// - Busy sets at master transfer start, except single-wire receive, and on the slave's second serial edge.
// - Busy clears at transfer end, on disable and on master fault.
// - Master continuous transfers keep busy high throughout, except in single-wire receive.
// - Slave busy drops for at least one serial clock between bytes.
// - Master discontinuous busy sets two clocks after the data write.
// - Master receive-only runs the clock continuously while enabled.
// - Slave receives only while select is low and clock runs.
// - Second unread received byte raises the overrun flag.
// - Master keeps clocking without gap when next data is ready.
// - Master stops clock and clears busy when data comes late.
// - Two independent serial checksum accumulators with programmable polynomial.
// - Checksums update on the sampling edge set by polarity and phase.
// - Enabling the checksum resets both accumulators.
// - Send-checksum request shifts out the transmit checksum after current byte.
// - A pending buffered byte goes out before the checksum.
// - Both accumulators freeze while the checksum is sent.
// - Checksum mismatch sets error flag and interrupt when enabled.
// - Send-checksum request clears itself after the checksum is sent.
// - Each data transfer loads the buffered byte, or zero when none is pending, into an 8-bit shifter.
// - Transmit-empty sets when the buffer moves into the shifter.
// - Receive-full sets on the last sampling edge of a byte.
module spcrc_core
  import spcrc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Serial pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_nss_n,
  // Error request
  output logic o_err_irq
);
  import spcrc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  spcrc_ctrl_t ctrl;
  spcrc_ctrl_t wr_ctrl_val;
  spcrc_req_t ph;
  spcrc_mstate_t mstate;
  logic [7:0] poly, tx_buf, rx_buf, tx_sh, rx_sh, rx_byte, tx_crc, rx_crc, load_val;
  logic tx_buf_empty, rx_buf_full, overrun_flag, ovr_armed, master_fault_flag, master_fault_flag_armed;
  logic checksum_error, link_busy, crc_phase, slv_loaded, sck_lvl;
  logic [9:0] half_cnt, half_len;
  logic [3:0] edge_cnt;
  logic sck_m, sck_s, sck_d, mosi_m, mosi_s, miso_m, miso_s, nss_m, nss_s;
  logic acc, rd_dr, rd_sr, wr_dr, wr_ctrl, wr_sr, crc_clear;
  logic rx_mode, tx_on, rx_on, is_master, en, slv_sel, fault_det;
  logic m_edge, s_edge, edge_ev, samp_ev, shift_ev, last_edge, rx_done, rx_in, tx_bit;
  logic have_data, want_crc, m_go, load_ev, take_tx, crc_start, crc_end, crc_step;
  logic [31:0] rd_val;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {sck_m, sck_s, sck_d} <= 3'h0;
      {mosi_m, mosi_s, miso_m, miso_s} <= 4'h0;
      {nss_m, nss_s} <= 2'h3;
    end else begin
      sck_m <= i_sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      mosi_m <= i_mosi;
      mosi_s <= mosi_m;
      miso_m <= i_miso;
      miso_s <= miso_m;
      nss_m <= i_nss_n;
      nss_s <= nss_m;
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  // Zero wait states: every transfer completes in its first data phase cycle.
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign acc = i_hsel && i_htrans[1] && i_hready;
  assign rd_dr = acc && !i_hwrite && (i_haddr[7:0] == `SPCRC_OFF_DATA);
  assign rd_sr = acc && !i_hwrite && (i_haddr[7:0] == `SPCRC_OFF_STAT);
  assign wr_dr = ph.sel && ph.write && (ph.addr == `SPCRC_OFF_DATA);
  assign wr_ctrl = ph.sel && ph.write && (ph.addr == `SPCRC_OFF_CTRL);
  assign wr_sr = ph.sel && ph.write && (ph.addr == `SPCRC_OFF_STAT);
  assign wr_ctrl_val = spcrc_ctrl_t'(i_hwdata[$bits(spcrc_ctrl_t)-1:0]);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (i_haddr[7:0])
      `SPCRC_OFF_CTRL: rd_val[$bits(spcrc_ctrl_t)-1:0] = ctrl;
      `SPCRC_OFF_STAT: begin
        rd_val[`SPCRC_ST_TXE] = tx_buf_empty;
        rd_val[`SPCRC_ST_RX_BUF_FULL] = rx_buf_full;
        rd_val[`SPCRC_ST_CHECKSUM_ERROR] = checksum_error;
        rd_val[`SPCRC_ST_MASTER_FAULT_FLAG] = master_fault_flag;
        rd_val[`SPCRC_ST_OVR] = overrun_flag;
        rd_val[`SPCRC_ST_BUSY] = link_busy;
      end
      `SPCRC_OFF_DATA: rd_val[7:0] = rx_buf;
      `SPCRC_OFF_POLY: rd_val[7:0] = poly;
      `SPCRC_OFF_TXCRC: rd_val[7:0] = tx_crc;
      `SPCRC_OFF_RXCRC: rd_val[7:0] = rx_crc;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph <= '0;
      o_hrdata <= 32'h0000_0000;
    end else begin
      ph <= '{sel: acc, write: i_hwrite, addr: i_haddr[7:0]};
      if (acc && !i_hwrite) begin
        o_hrdata <= rd_val;
      end
    end
  end

  // ****************************************************************
  // Control and polynomial registers
  // ****************************************************************
  assign crc_clear = wr_ctrl && wr_ctrl_val.checksum_enable && !ctrl.checksum_enable;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= `SPCRC_RST_CTRL;
      poly <= `SPCRC_RST_POLY;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wr_ctrl_val;
        // Enable and master stay low while a fault is pending.
        if (master_fault_flag) begin
          ctrl.periph_enable <= 1'b0;
          ctrl.master_select <= 1'b0;
        end
      end
      if (crc_end) begin
        ctrl.send_checksum_next <= 1'b0;
      end
      if (fault_det) begin
        ctrl.periph_enable <= 1'b0;
        ctrl.master_select <= 1'b0;
      end
      if (ph.sel && ph.write && ph.addr == `SPCRC_OFF_POLY) begin
        poly <= i_hwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Mode decode and serial edges
  // ****************************************************************
  assign en = ctrl.periph_enable;
  assign is_master = ctrl.master_select;
  assign rx_mode = ctrl.receive_only || (ctrl.single_wire_mode && !ctrl.single_wire_out_en);
  assign tx_on = !rx_mode;
  assign rx_on = !(ctrl.single_wire_mode && ctrl.single_wire_out_en);
  assign fault_det = en && is_master && !nss_s;
  assign slv_sel = en && !is_master && !nss_s;
  assign rx_in = is_master ? (ctrl.single_wire_mode ? mosi_s : miso_s)
                           : (ctrl.single_wire_mode ? miso_s : mosi_s);
  assign tx_bit = ctrl.lsb_first ? tx_sh[0] : tx_sh[7];
  assign half_len = (`SPCRC_HALF_BASE << ctrl.baud) - 10'h001;
  assign m_edge = (mstate == M_XFER) && (half_cnt == 10'h000);
  assign s_edge = slv_sel && (sck_s != sck_d);
  assign edge_ev = is_master ? m_edge : s_edge;
  assign samp_ev = edge_ev && (edge_cnt[0] == ctrl.cpha);
  assign shift_ev = edge_ev && (edge_cnt[0] != ctrl.cpha) && (edge_cnt != 4'h0);
  assign last_edge = edge_ev && (edge_cnt == `SPCRC_LAST_EDGE);
  assign rx_done = samp_ev && (edge_cnt[3:1] == 3'h7) && rx_on;
  assign rx_byte = ctrl.lsb_first ? {rx_in, rx_sh[7:1]} : {rx_sh[6:0], rx_in};

  // ****************************************************************
  // Byte sourcing
  // ****************************************************************
  assign have_data = !tx_buf_empty && tx_on;
  assign want_crc = ctrl.checksum_enable && ctrl.send_checksum_next && tx_on;
  // Next byte is ready before the last edge, so the clock runs on without a gap.
  assign m_go = en && !fault_det && !wr_dr
                && (rx_mode || have_data || (want_crc && !crc_phase));
  assign load_ev = is_master ? (((mstate == M_START) && !wr_dr) || (last_edge && m_go))
                             : (slv_sel && !slv_loaded && !wr_dr);
  assign take_tx = load_ev && have_data;
  // The request is still set on the checksum's own last edge, so it must not start a second one.
  assign crc_start = load_ev && !have_data && want_crc && !crc_phase;
  assign crc_end = last_edge && crc_phase;
  assign load_val = take_tx ? tx_buf : (crc_start ? tx_crc : 8'h00);

  // ****************************************************************
  // Master sequencer
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mstate <= M_IDLE;
    end else if (!en || !is_master || fault_det) begin
      mstate <= M_IDLE;
    end else begin
      unique case (mstate)
        M_IDLE: if (rx_mode || have_data || want_crc) mstate <= M_START;
        M_START: if (!wr_dr) mstate <= M_XFER;
        M_XFER: if (last_edge && !m_go) mstate <= M_IDLE;
        default: mstate <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      half_cnt <= 10'h000;
      sck_lvl <= 1'b0;
    end else if (mstate == M_XFER) begin
      half_cnt <= (half_cnt == 10'h000) ? half_len : half_cnt - 10'h001;
      if (m_edge) begin
        sck_lvl <= !sck_lvl;
      end
    end else begin
      half_cnt <= half_len;
      sck_lvl <= ctrl.cpol;
    end
  end

  // ****************************************************************
  // Shifters and edge counting
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      edge_cnt <= 4'h0;
      slv_loaded <= 1'b0;
      tx_sh <= `SPCRC_RST_DATA;
      rx_sh <= `SPCRC_RST_DATA;
      crc_phase <= 1'b0;
    end else begin
      if (is_master ? (mstate != M_XFER) : !slv_sel) begin
        edge_cnt <= 4'h0;
      end else if (edge_ev) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
      if (!slv_sel || last_edge) begin
        slv_loaded <= 1'b0;
      end else if (load_ev) begin
        slv_loaded <= 1'b1;
      end
      if (load_ev) begin
        tx_sh <= load_val;
      end else if (shift_ev) begin
        tx_sh <= ctrl.lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
      end
      if (samp_ev) begin
        rx_sh <= rx_byte;
      end
      if (!en) begin
        crc_phase <= 1'b0;
      end else if (load_ev) begin
        crc_phase <= crc_start;
      end else if (last_edge) begin
        crc_phase <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Buffers and flags
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_buf <= `SPCRC_RST_DATA;
      tx_buf_empty <= 1'b1;
    end else if (wr_dr) begin
      tx_buf <= i_hwdata[7:0];
      tx_buf_empty <= 1'b0;
    end else if (take_tx) begin
      tx_buf_empty <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_buf <= `SPCRC_RST_DATA;
      rx_buf_full <= 1'b0;
    end else if (rx_done && (!rx_buf_full || rd_dr)) begin
      rx_buf <= rx_byte;
      rx_buf_full <= 1'b1;
    end else if (rd_dr) begin
      rx_buf_full <= 1'b0;
    end
  end

  // Overrun clears on a data read followed by a status read; a new overrun wins.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      overrun_flag <= 1'b0;
      ovr_armed <= 1'b0;
    end else if (rx_done && rx_buf_full && !rd_dr) begin
      overrun_flag <= 1'b1;
      ovr_armed <= 1'b0;
    end else if (rd_sr && ovr_armed) begin
      overrun_flag <= 1'b0;
      ovr_armed <= 1'b0;
    end else if (rd_dr && overrun_flag) begin
      ovr_armed <= 1'b1;
    end
  end

  // Fault clears on a status access followed by a control write.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      master_fault_flag <= 1'b0;
      master_fault_flag_armed <= 1'b0;
    end else if (fault_det) begin
      master_fault_flag <= 1'b1;
      master_fault_flag_armed <= 1'b0;
    end else if (wr_ctrl && master_fault_flag_armed) begin
      master_fault_flag <= 1'b0;
      master_fault_flag_armed <= 1'b0;
    end else if ((rd_sr || wr_sr) && master_fault_flag) begin
      master_fault_flag_armed <= 1'b1;
    end
  end

  // Mismatch is cleared by writing zero to its status bit; a new mismatch wins.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      checksum_error <= 1'b0;
    end else if (rx_done && crc_phase && (rx_byte != rx_crc)) begin
      checksum_error <= 1'b1;
    end else if (wr_sr && !i_hwdata[`SPCRC_ST_CHECKSUM_ERROR]) begin
      checksum_error <= 1'b0;
    end
  end

  // Status writes never reach this flag.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link_busy <= 1'b0;
    end else if (!en || fault_det) begin
      link_busy <= 1'b0;
    end else if (is_master) begin
      if (load_ev) begin
        link_busy <= !(ctrl.single_wire_mode && !ctrl.single_wire_out_en);
      end else if (last_edge && !m_go) begin
        link_busy <= 1'b0;
      end
    end else if (!slv_sel) begin
      link_busy <= 1'b0;
    end else if (samp_ev && edge_cnt[3:1] == 3'h7) begin
      link_busy <= 1'b0;
    end else if (edge_ev && edge_cnt == 4'h1) begin
      // Raised on the second edge so the gap spans at least one serial period.
      link_busy <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_err_irq <= 1'b0;
    end else begin
      o_err_irq <= ctrl.error_irq_enable && (checksum_error || overrun_flag || master_fault_flag);
    end
  end

  // ****************************************************************
  // Checksums
  // ****************************************************************
  assign crc_step = samp_ev && ctrl.checksum_enable && !crc_phase;

  spcrc_crc8 u_tx_crc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(crc_clear),
    .i_step(crc_step && tx_on),
    .i_bit(tx_bit),
    .i_poly(poly),
    .o_crc(tx_crc)
  );

  spcrc_crc8 u_rx_crc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(crc_clear),
    .i_step(crc_step && rx_on),
    .i_bit(rx_in),
    .i_poly(poly),
    .o_crc(rx_crc)
  );

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  assign o_sck = sck_lvl;
  assign o_sck_oe = en && is_master;
  assign o_mosi = tx_bit;
  assign o_mosi_oe = en && is_master && tx_on;
  assign o_miso = tx_bit;
  assign o_miso_oe = slv_sel && tx_on;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_txe_clear;
    wr_dr |=> !tx_buf_empty;
  endproperty
  a_txe_clear: assert property (p_txe_clear) else $error("empty flag not cleared by write");

  property p_rx_buf_full_clear;
    (rd_dr && !rx_done) |=> !rx_buf_full;
  endproperty
  a_rx_buf_full_clear: assert property (p_rx_buf_full_clear) else $error("full flag not cleared by read");

  property p_busy_delay;
    (wr_dr && tx_buf_empty && mstate == M_IDLE && en && is_master && tx_on && !link_busy && nss_s)
      ##1 nss_s ##1 (nss_s && !wr_dr)
      |-> (!$past(link_busy) && !link_busy) ##1 link_busy;
  endproperty
  a_busy_delay: assert property (p_busy_delay) else $error("busy not set two clocks after write");

  property p_busy_off;
    (!en || fault_det) |=> !link_busy;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy high after disable or fault");

  property p_fault;
    fault_det |=> master_fault_flag && !ctrl.periph_enable && !ctrl.master_select;
  endproperty
  a_fault: assert property (p_fault) else $error("master fault not handled");

  property p_overrun;
    (rx_done && rx_buf_full && !rd_dr) |=> overrun_flag && (rx_buf == $past(rx_buf));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_rx_buf_full_set;
    rx_done |=> rx_buf_full;
  endproperty
  a_rx_buf_full_set: assert property (p_rx_buf_full_set) else $error("full flag not set on last sample");

  property p_txe_load;
    (take_tx && !wr_dr) |=> tx_buf_empty && (tx_sh == $past(tx_buf));
  endproperty
  a_txe_load: assert property (p_txe_load) else $error("buffer not moved to shifter");

  property p_crc_freeze;
    (crc_phase && !crc_clear) |=> (tx_crc == $past(tx_crc)) && (rx_crc == $past(rx_crc));
  endproperty
  a_crc_freeze: assert property (p_crc_freeze) else $error("checksum moved while sent");

  property p_crc_init;
    crc_clear |=> (tx_crc == 8'h00) && (rx_crc == 8'h00);
  endproperty
  a_crc_init: assert property (p_crc_init) else $error("checksums not reset on enable");

  property p_send_checksum_next_clr;
    (crc_end && !wr_ctrl) |=> !ctrl.send_checksum_next;
  endproperty
  a_send_checksum_next_clr: assert property (p_send_checksum_next_clr) else $error("send request not cleared");

  property p_cont;
    (is_master && last_edge && m_go && link_busy) |=> link_busy && (mstate == M_XFER);
  endproperty
  a_cont: assert property (p_cont) else $error("busy dropped in continuous run");
endmodule
`default_nettype wire

/* verilog/spcrc_regs.svh */
// Register offsets, field positions, reset values and timing counts of the SPI block.
`ifndef SPCRC_REGS_SVH
`define SPCRC_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses on the bus)
// ****************************************************************
`define SPCRC_OFF_CTRL 8'h00
`define SPCRC_OFF_STAT 8'h04
`define SPCRC_OFF_DATA 8'h08
`define SPCRC_OFF_POLY 8'h0c
`define SPCRC_OFF_TXCRC 8'h10
`define SPCRC_OFF_RXCRC 8'h14

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define SPCRC_ST_TXE 0
`define SPCRC_ST_RX_BUF_FULL 1
`define SPCRC_ST_CHECKSUM_ERROR 4
`define SPCRC_ST_MASTER_FAULT_FLAG 5
`define SPCRC_ST_OVR 6
`define SPCRC_ST_BUSY 7

// ****************************************************************
// Reset values
// ****************************************************************
`define SPCRC_RST_CTRL 14'h0000
`define SPCRC_RST_POLY 8'h07
`define SPCRC_RST_CRC 8'h00
`define SPCRC_RST_DATA 8'h00

// ****************************************************************
// Timing: half serial period in system clocks at the fastest divider step, and last edge count
// ****************************************************************
`define SPCRC_HALF_BASE 10'h004
`define SPCRC_LAST_EDGE 4'hf

`endif

/* verilog/spcrc_pkg.sv */
// Types shared by the SPI transfer, status and checksum block.
package spcrc_pkg;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic [2:0] baud;
    logic error_irq_enable;
    logic send_checksum_next;
    logic checksum_enable;
    logic receive_only;
    logic single_wire_out_en;
    logic single_wire_mode;
    logic lsb_first;
    logic cpha;
    logic cpol;
    logic master_select;
    logic periph_enable;
  } spcrc_ctrl_t;

  // Captured bus address phase.
  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } spcrc_req_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_START = 2'b01,
    M_XFER = 2'b10
  } spcrc_mstate_t;

endpackage

/* verilog/spcrc_crc8.sv */
// Serial checksum accumulator with a programmable polynomial.
`timescale 1ns/1ns
`default_nettype none
`include "spcrc_regs.svh"
module spcrc_crc8 (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clear,
  input wire logic i_step,
  input wire logic i_bit,
  input wire logic [7:0] i_poly,
  // Result
  output logic [7:0] o_crc
);
  logic fb;

  assign fb = i_bit ^ o_crc[7];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_crc <= `SPCRC_RST_CRC;
    end else if (i_clear) begin
      o_crc <= `SPCRC_RST_CRC;
    end else if (i_step) begin
      o_crc <= {o_crc[6:0], 1'b0} ^ (fb ? i_poly : 8'h00);
    end
  end
endmodule
`default_nettype wire

/* test/spcrc_slave_model.sv */
// Behavioural SPI slave that stands on the far side of the master link.
`timescale 1ns/1ns
`default_nettype none
module spcrc_slave_model (
  // Serial side
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  // Bench control
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  output logic [7:0] o_rx
);
  logic [7:0] sh;
  initial begin
    sh = 8'h00;
    o_rx = 8'h00;
  end
  // Mode zero: sample on the rising edge, shift on the falling edge.
  always @(posedge i_sck) o_rx <= {o_rx[6:0], i_mosi};
  // Refilling with the inverted bit keeps a stale line from looking like data.
  always @(negedge i_sck) sh <= {sh[6:0], ~sh[7]};
  always @(posedge i_load) sh <= i_byte;
  assign o_miso = sh[7];
endmodule
`default_nettype wire

/* test/spi_transfer_crc_status_tb.sv */
// Bus-driven bench for the SPI transfer, status and checksum block.
`timescale 1ns/1ns
`default_nettype none
`include "spcrc_regs.svh"
module spi_transfer_crc_status_tb;
  import spcrc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ld = 1'b0, gap = 1'b0;
  logic [7:0] sb = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire logic hready, sck, mosi, miso, irq;
  wire logic [31:0] hrdata;
  logic [7:0] rx;
  int fails = 0, n_tests = 0, cyc = 0;
  always #50 clk = ~clk;
  spcrc_core u_spcrc_core (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(), .o_hrdata(hrdata),
    .i_sck(sck), .o_sck(sck), .o_sck_oe(), .i_mosi(mosi), .o_mosi(mosi), .o_mosi_oe(),
    .i_miso(miso), .o_miso(), .o_miso_oe(), .i_nss_n(1'b1), .o_err_irq(irq));
  spcrc_slave_model u_spcrc_slave_model (.i_sck(sck), .i_mosi(mosi), .o_miso(miso),
    .i_load(ld), .i_byte(sb), .o_rx(rx));
  // ****************************************************************
  // Bus master and checking
  // ****************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  // Software polls status until one read shows empty and not busy before moving on.
  task automatic wait_done();
    repeat (4) @(posedge clk);
    r = 32'h80;
    while (r[0] !== 1'b1 || r[7] !== 1'b0) bus(1'b0, `SPCRC_OFF_STAT, 32'h0);
  endtask
  // Preloads the far side with the byte that it answers with.
  task automatic arm(input logic [7:0] s);
    sb <= s;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] s);
    arm(s);
    bus(1'b1, `SPCRC_OFF_DATA, {24'h000000, b});
  endtask
  // Polls status until one bit reads the wanted level; any idle busy reading is noted.
  task automatic poll(input int b, input logic v);
    r = {32{~v}};
    while (r[b] !== v) begin
      bus(1'b0, `SPCRC_OFF_STAT, 32'h0);
      if (r[7] !== 1'b1) gap = 1'b1;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(`SPCRC_OFF_STAT, 32'h01);
    rdchk(`SPCRC_OFF_TXCRC, 32'h0);
    rdchk(`SPCRC_OFF_RXCRC, 32'h0);
    rdchk(8'h18, 32'h0);
    $display("reset test done");
    bus(1'b1, `SPCRC_OFF_STAT, 32'h80);
    rdchk(`SPCRC_OFF_STAT, 32'h01);
    bus(1'b1, `SPCRC_OFF_CTRL, 32'h03);
    rdchk(`SPCRC_OFF_CTRL, 32'h03);
    $display("register test done");
    send(8'h3c, 8'ha5);
    rdchk(`SPCRC_OFF_STAT, 32'h00);
    wait_done();
    chk(r, 32'h03);
    chk({24'h0, rx}, 32'h3c);
    rdchk(`SPCRC_OFF_DATA, 32'ha5);
    rdchk(`SPCRC_OFF_STAT, 32'h01);
    $display("transfer test done");
    send(8'h81, 8'h7e);
    wait_done();
    send(8'h7e, 8'h81);
    wait_done();
    chk(r, 32'h43);
    chk({24'h0, rx}, 32'h7e);
    rdchk(`SPCRC_OFF_DATA, 32'h7e);
    rdchk(`SPCRC_OFF_STAT, 32'h41);
    rdchk(`SPCRC_OFF_STAT, 32'h01);
    $display("overrun test done");
    send(8'h11, 8'h22);
    poll(0, 1'b1);
    chk(r, 32'h81);
    gap = 1'b0;
    bus(1'b1, `SPCRC_OFF_DATA, 32'h33);
    poll(0, 1'b1);
    chk({31'h0, gap}, 32'h0);
    rdchk(`SPCRC_OFF_DATA, 32'h22);
    wait_done();
    chk({24'h0, rx}, 32'h33);
    rdchk(`SPCRC_OFF_DATA, 32'hdd);
    $display("continuous test done");
    bus(1'b1, `SPCRC_OFF_CTRL, 32'h103);
    send(8'h01, 8'hfe);
    wait_done();
    rdchk(`SPCRC_OFF_DATA, 32'hfe);
    rdchk(`SPCRC_OFF_TXCRC, 32'h07);
    rdchk(`SPCRC_OFF_RXCRC, 32'hf4);
    arm(8'h00);
    bus(1'b1, `SPCRC_OFF_CTRL, 32'h703);
    wait_done();
    chk(r, 32'h13);
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, rx}, 32'h07);
    rdchk(`SPCRC_OFF_CTRL, 32'h503);
    rdchk(`SPCRC_OFF_TXCRC, 32'h07);
    rdchk(`SPCRC_OFF_RXCRC, 32'hf4);
    bus(1'b1, `SPCRC_OFF_CTRL, 32'h003);
    bus(1'b1, `SPCRC_OFF_CTRL, 32'h103);
    rdchk(`SPCRC_OFF_TXCRC, 32'h00);
    rdchk(`SPCRC_OFF_RXCRC, 32'h00);
    $display("checksum test done");
    conclude();
  end
endmodule
`default_nettype wire
